// ==== include/eeprom_link_pkg.sv ====
// Shared constants and helpers for the two-wire serial EEPROM link
package eeprom_link_pkg;

  // Timing, expressed in the printed unit and converted to sys_clk cycles
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_WR_MS = 6;
  localparam int WR_CYCLES_DFLT = T_WR_MS * 1000000 / CLK_PERIOD_NS;
  localparam int WR_TMR_W = 21;
  localparam int T_QUARTER_NS = 800;
  localparam int QUARTER_CYCLES_DFLT = (T_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUARTER_W = 8;

  // Slave address byte layout: type, select, direction
  localparam int BYTE_W = 8;
  localparam int SA_TYPE_LSB = 4;
  localparam int SA_TYPE_W = 4;
  localparam int SA_SEL_LSB = 1;
  localparam int SA_SEL_W = 3;
  localparam int SA_RW_BIT = 0;
  localparam logic [3:0] DEV_TYPE_DFLT = 4'h6;  // Arbitrary value, set per system
  localparam logic RW_READ = 1'h1;
  localparam logic RW_WRITE = 1'h0;

  // Array address: top bit of the high byte is unused
  localparam int ADDR_W = 15;
  localparam int ADDR_HI_USED = 7;
  localparam logic ADDR_TOP_FILL = 1'h0;

  // Bit clock numbering within one byte frame
  localparam logic [3:0] LAST_DATA_CLK = 4'h8;
  localparam logic [3:0] ACK_CLK = 4'h9;
  localparam logic ACK_LEVEL = 1'h0;

  // Builds the slave address byte
  function automatic logic [BYTE_W-1:0] slave_addr(input logic [SA_TYPE_W-1:0] dev_type,
                                                   input logic [SA_SEL_W-1:0] sel,
                                                   input logic rw);
    slave_addr = {dev_type, sel, rw};
  endfunction

endpackage

// ==== include/eeprom_link_if.sv ====
// Two-wire link between the bus master end and the EEPROM slave end
`timescale 1ns/100ps
`default_nettype none

interface eeprom_link_if;
  logic scl;
  logic sda;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic chip_select_pin_high;
  logic chip_select_pin_mid;
  logic chip_select_pin_low;
  logic wp_drive;
  logic wp_drive_en;
  logic write_protect_pin;

  // Open-drain data wire with pull-up: low while any end pulls it low
  assign sda = !((!host_sda_oe_n && !host_sda_o) || (!dev_sda_oe_n && !dev_sda_o));

  // Protect pin floats to low through its pull-down
  assign write_protect_pin = wp_drive_en ? wp_drive : 1'h0;

  modport dev (
    input scl,
    input sda,
    output dev_sda_o,
    output dev_sda_oe_n,
    input chip_select_pin_high,
    input chip_select_pin_mid,
    input chip_select_pin_low,
    input write_protect_pin
  );

  modport host (
    output scl,
    input sda,
    output host_sda_o,
    output host_sda_oe_n
  );
endinterface

`default_nettype wire

// ==== rtl/eeprom_master_end.v.sv ====
// Bus master end: issues one byte write per request and reports acknowledges
`timescale 1ns/100ps
`default_nettype none

module eeprom_master_end
  import eeprom_link_pkg::*;
#(
  parameter logic [SA_TYPE_W-1:0] DEV_TYPE = DEV_TYPE_DFLT,
  parameter int unsigned QUARTER_CYCLES = QUARTER_CYCLES_DFLT
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  eeprom_link_if.host link,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [SA_SEL_W-1:0] req_sel,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [BYTE_W-1:0] req_data,
  output logic done,
  output logic nack,
  output logic [1:0] nack_byte
);

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_START = 3'h1,
    H_BIT = 3'h2,
    H_ACK = 3'h3,
    H_STOP = 3'h4
  } host_state_t;

  typedef struct packed {
    host_state_t state;
    logic [1:0] ph;
    logic [QUARTER_W-1:0] tick;
    logic [2:0] bitn;
    logic [1:0] byten;
    logic [BYTE_W-1:0] sh;
    logic sda_m;
    logic sda_s;
    logic scl;
    logic sda_oe_n;
    logic sda_o;
    logic ready;
    logic done;
    logic nack;
    logic [1:0] nack_byte;
    logic [SA_SEL_W-1:0] sel;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] data;
  } host_t;

  host_t h_q;
  host_t h_d;
  logic qtr;

  // Byte sent after byte k-1 of the write sequence
  function automatic logic [BYTE_W-1:0] next_byte(input host_t h, input logic [1:0] k);
    case (k)
      2'h1: next_byte = {ADDR_TOP_FILL, h.addr[ADDR_W-1:BYTE_W]};
      2'h2: next_byte = h.addr[BYTE_W-1:0];
      default: next_byte = h.data;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Quarter-period sequencer; SCL is derived here by division
  always_comb begin
    h_d = h_q;
    qtr = (h_q.tick == QUARTER_W'(QUARTER_CYCLES - 1));
    h_d.sda_m = link.sda;
    h_d.sda_s = h_q.sda_m;
    h_d.done = 1'h0;
    if (h_q.state != H_IDLE) begin
      h_d.tick = qtr ? '0 : h_q.tick + 1'h1;
    end
    if (qtr) begin
      h_d.ph = h_q.ph + 2'h1;
    end
    case (h_q.state)
      H_IDLE: begin
        if (req_valid && h_q.ready) begin
          h_d.ready = 1'h0;
          h_d.nack = 1'h0;
          h_d.sel = req_sel;
          h_d.addr = req_addr;
          h_d.data = req_data;
          h_d.tick = '0;
          h_d.ph = 2'h0;
          h_d.state = H_START;
        end
      end
      // SDA falls while SCL is high
      H_START: begin
        if (qtr && h_q.ph == 2'h0) h_d.sda_oe_n = 1'h0;
        if (qtr && h_q.ph == 2'h2) h_d.scl = 1'h0;
        if (qtr && h_q.ph == 2'h3) begin
          h_d.state = H_BIT;
          h_d.bitn = 3'h7;
          h_d.byten = 2'h0;
          h_d.sh = slave_addr(DEV_TYPE, h_q.sel, RW_WRITE);
        end
      end
      // Data changes only with SCL low, MSB first
      H_BIT: begin
        if (qtr && h_q.ph == 2'h0) h_d.sda_oe_n = h_q.sh[BYTE_W-1];
        if (qtr && h_q.ph == 2'h1) h_d.scl = 1'h1;
        if (qtr && h_q.ph == 2'h3) begin
          h_d.scl = 1'h0;
          h_d.sh = {h_q.sh[BYTE_W-2:0], 1'h0};
          h_d.bitn = h_q.bitn - 3'h1;
          // Let go of SDA with the eighth fall so the receiver's pull never meets ours
          if (h_q.bitn == 3'h0) begin
            h_d.sda_oe_n = 1'h1;
            h_d.state = H_ACK;
          end
        end
      end
      // Release SDA and sample the receiver's answer on the ninth clock
      H_ACK: begin
        if (qtr && h_q.ph == 2'h0) h_d.sda_oe_n = 1'h1;
        if (qtr && h_q.ph == 2'h1) h_d.scl = 1'h1;
        if (qtr && h_q.ph == 2'h2 && h_q.sda_s != ACK_LEVEL) begin
          h_d.nack = 1'h1;
          h_d.nack_byte = h_q.byten;
        end
        if (qtr && h_q.ph == 2'h3) begin
          h_d.scl = 1'h0;
          if (h_q.nack || h_q.byten == 2'h3) begin
            h_d.state = H_STOP;
          end else begin
            h_d.byten = h_q.byten + 2'h1;
            h_d.sh = next_byte(h_q, h_q.byten + 2'h1);
            h_d.bitn = 3'h7;
            h_d.state = H_BIT;
          end
        end
      end
      // SDA rises while SCL is high
      H_STOP: begin
        if (qtr && h_q.ph == 2'h0) h_d.sda_oe_n = 1'h0;
        if (qtr && h_q.ph == 2'h1) h_d.scl = 1'h1;
        if (qtr && h_q.ph == 2'h2) h_d.sda_oe_n = 1'h1;
        if (qtr && h_q.ph == 2'h3) begin
          h_d.state = H_IDLE;
          h_d.done = 1'h1;
          h_d.ready = 1'h1;
        end
      end
      default: h_d.state = H_IDLE;
    endcase
    if (rst) begin
      h_d = '0;
      h_d.scl = 1'h1;
      h_d.sda_oe_n = 1'h1;
      h_d.ready = 1'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || clk_en) begin
      h_q <= h_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign link.scl = h_q.scl;
  assign link.host_sda_o = h_q.sda_o;
  assign link.host_sda_oe_n = h_q.sda_oe_n;
  assign req_ready = h_q.ready;
  assign done = h_q.done;
  assign nack = h_q.nack;
  assign nack_byte = h_q.nack_byte;

endmodule

`default_nettype wire

// ==== rtl/eeprom_slave_end.sv ====
// Serial EEPROM slave end: byte capture on SCL, framing and write timer on sys_clk
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Slave address: type, select, direction bit
// - All four type bits must match
// - Select bits match pins, MSB first
// - Direction bit: one reads, zero writes
// - Receiver pulls SDA low on ninth clock
// - Transmitter releases SDA, samples ninth clock
// - Array address: high byte, then low
// - High byte top bit ignored, sent zero
// - SDA only pulled low or released
// - Protect pin high blocks all programming
// - Protected: address acked, data not acked
// - Floating protect pin reads low
// - Master changes SDA only while SCL low
// - Start: SDA falls, SCL high; wait for it
// - Stop: SDA rises, SCL high; go idle
// - Master supplies SCL; slave never drives it
// - Byte write then stop launches write
// - Ignore everything while write cycle runs
// - Write lasts six ms, no acknowledge
module eeprom_slave_end
  import eeprom_link_pkg::*;
#(
  parameter logic [SA_TYPE_W-1:0] DEV_TYPE = DEV_TYPE_DFLT,
  parameter int unsigned WR_CYCLES = WR_CYCLES_DFLT
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  eeprom_link_if.dev link,
  output logic wr_strobe,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [BYTE_W-1:0] wr_data,
  output logic write_busy
);

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_SADDR = 3'h1,
    S_AHI = 3'h2,
    S_ALO = 3'h3,
    S_DATA = 3'h4,
    S_SKIP = 3'h5
  } slave_state_t;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic [SA_SEL_W-1:0] cs_m;
    logic [SA_SEL_W-1:0] cs_s;
    logic wp_m;
    logic wp_s;
    slave_state_t state;
    slave_state_t nxt;
    logic [3:0] cnt;
    logic ack_pend;
    logic ack_drive;
    logic arm;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] data;
    logic busy;
    logic [WR_TMR_W-1:0] timer;
    logic sda_oe_n;
    logic sda_o;
    logic wr_strobe;
    logic [ADDR_W-1:0] wr_addr;
    logic [BYTE_W-1:0] wr_data;
  } slave_t;

  slave_t s_q;
  slave_t s_d;
  logic [BYTE_W-1:0] rx_sh_q;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  // Address match: type field and select field against the pins
  function automatic logic addr_match(input logic [BYTE_W-1:0] sa,
                                      input logic [SA_SEL_W-1:0] pins);
    addr_match = (sa[SA_TYPE_LSB +: SA_TYPE_W] == DEV_TYPE) &&
                 (sa[SA_SEL_LSB +: SA_SEL_W] == pins);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link clock domain: shift in SDA on each SCL rise, MSB first.
  // The word is read by sys_clk only after a synchronised rise, while it is
  // held steady for the whole SCL high and low that follow.
  always_ff @(posedge link.scl) begin
    rx_sh_q <= {rx_sh_q[BYTE_W-2:0], link.sda};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus condition decode from the synchronised pins
  always_comb begin
    scl_rise = s_q.scl_s && !s_q.scl_p;
    scl_fall = !s_q.scl_s && s_q.scl_p;
    start_cond = s_q.scl_s && s_q.scl_p && s_q.sda_p && !s_q.sda_s;
    stop_cond = s_q.scl_s && s_q.scl_p && !s_q.sda_p && s_q.sda_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Framing, acknowledge and write-cycle control
  always_comb begin
    s_d = s_q;
    // Two-flop synchronisers for every pin input
    s_d.scl_m = link.scl;
    s_d.scl_s = s_q.scl_m;
    s_d.scl_p = s_q.scl_s;
    s_d.sda_m = link.sda;
    s_d.sda_s = s_q.sda_m;
    s_d.sda_p = s_q.sda_s;
    s_d.cs_m = {link.chip_select_pin_high, link.chip_select_pin_mid, link.chip_select_pin_low};
    s_d.cs_s = s_q.cs_m;
    s_d.wp_m = link.write_protect_pin;
    s_d.wp_s = s_q.wp_m;
    s_d.wr_strobe = 1'h0;

    if (s_q.busy) begin
      // Deaf and silent until the write time has run out
      s_d.state = S_IDLE;
      s_d.ack_drive = 1'h0;
      if (s_q.timer == '0) begin
        s_d.busy = 1'h0;
      end else begin
        s_d.timer = s_q.timer - 1'h1;
      end
    end else if (start_cond) begin
      // A start, or a repeated start, opens a fresh frame
      s_d.state = S_SADDR;
      s_d.cnt = 4'h0;
      s_d.ack_drive = 1'h0;
      s_d.arm = 1'h0;
    end else if (stop_cond) begin
      s_d.state = S_IDLE;
      s_d.cnt = 4'h0;
      s_d.ack_drive = 1'h0;
      s_d.arm = 1'h0;
      if (s_q.arm) begin
        // Accepted data byte: launch the self-timed write
        s_d.busy = 1'h1;
        s_d.timer = WR_TMR_W'(WR_CYCLES - 1);
        s_d.wr_strobe = 1'h1;
        s_d.wr_addr = s_q.addr;
        s_d.wr_data = s_q.data;
      end
    end else if (s_q.state != S_IDLE) begin
      // Count SCL rises; the eighth completes the byte
      if (scl_rise && s_q.cnt != ACK_CLK) begin
        s_d.cnt = s_q.cnt + 4'h1;
        if (s_q.cnt + 4'h1 == LAST_DATA_CLK) begin
          s_d.ack_pend = 1'h1;
          s_d.nxt = s_q.state;
          case (s_q.state)
            S_SADDR: begin
              if (!addr_match(rx_sh_q, s_q.cs_s)) begin
                s_d.ack_pend = 1'h0;
                s_d.nxt = S_IDLE;
              end else if (rx_sh_q[SA_RW_BIT] == RW_READ) begin
                s_d.nxt = S_SKIP;
              end else begin
                s_d.nxt = S_AHI;
              end
            end
            S_AHI: begin
              s_d.addr[ADDR_W-1:BYTE_W] = rx_sh_q[ADDR_HI_USED-1:0];
              s_d.nxt = S_ALO;
            end
            S_ALO: begin
              s_d.addr[BYTE_W-1:0] = rx_sh_q;
              s_d.nxt = S_DATA;
            end
            S_DATA: begin
              if (s_q.wp_s) begin
                // Protected: refuse and forget the byte
                s_d.ack_pend = 1'h0;
                s_d.nxt = S_IDLE;
              end else begin
                s_d.data = rx_sh_q;
                s_d.arm = 1'h1;
                s_d.nxt = S_SKIP;
              end
            end
            default: begin
              s_d.ack_pend = 1'h0;
              s_d.nxt = S_SKIP;
            end
          endcase
        end
      end
      // Pull SDA after the eighth fall, let go after the ninth
      if (scl_fall && s_q.cnt == LAST_DATA_CLK) begin
        s_d.ack_drive = s_q.ack_pend;
      end
      if (scl_fall && s_q.cnt == ACK_CLK) begin
        s_d.ack_drive = 1'h0;
        s_d.cnt = 4'h0;
        s_d.state = s_q.nxt;
      end
    end

    // Open drain: the output level stays low, only the enable moves
    s_d.sda_o = 1'h0;
    s_d.sda_oe_n = !s_d.ack_drive;

    if (rst) begin
      s_d = '0;
      s_d.scl_m = 1'h1;
      s_d.scl_s = 1'h1;
      s_d.scl_p = 1'h1;
      s_d.sda_m = 1'h1;
      s_d.sda_s = 1'h1;
      s_d.sda_p = 1'h1;
      s_d.sda_oe_n = 1'h1;
    end
  end

  // Reset acts even while the clock enable is low
  always_ff @(posedge sys_clk) begin
    if (rst || clk_en) begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register; SCL is never driven here
  assign link.dev_sda_o = s_q.sda_o;
  assign link.dev_sda_oe_n = s_q.sda_oe_n;
  assign wr_strobe = s_q.wr_strobe;
  assign wr_addr = s_q.wr_addr;
  assign wr_data = s_q.wr_data;
  assign write_busy = s_q.busy;

endmodule

`default_nettype wire

// ==== verif/eeprom_link_props.sv ====
// Concurrent checks on the two-wire link between the master and slave ends
`timescale 1ns/100ps
`default_nettype none

module eeprom_link_props
  import eeprom_link_pkg::*;
#(
  parameter int unsigned WR_CYCLES = 1000
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic write_protect_pin,
  input wire logic wr_strobe,
  input wire logic write_busy
);
  typedef struct packed {
    logic [WR_TMR_W-1:0] busy_cnt;
  } chk_state_t;
  chk_state_t s_q;
  chk_state_t s_d;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // Counts the cycles of one internal write
  always_comb begin
    s_d = s_q;
    s_d.busy_cnt = write_busy ? s_q.busy_cnt + 1'h1 : '0;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link behaviour of the slave end
  open_drain_a: assert property (dev_sda_o == 1'h0)
    else $error("slave data output not low");
  ack_edge_a: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("slave data changed while clock high");
  ack_hold_a: assert property ($fell(dev_sda_oe_n) |-> !dev_sda_oe_n [*8])
    else $error("acknowledge pulse too short");
  ack_release_a: assert property ($fell(dev_sda_oe_n) |-> ##[8:60] $rose(dev_sda_oe_n))
    else $error("acknowledge not released in time");
  host_free_a: assert property (!dev_sda_oe_n |-> host_sda_oe_n)
    else $error("master holds data during acknowledge");
  busy_quiet_a: assert property (write_busy |-> dev_sda_oe_n)
    else $error("slave answers during write cycle");
  stop_launch_a: assert property (wr_strobe |-> scl && sda && write_busy && !$past(write_busy))
    else $error("write launched outside a stop");
  protect_block_a: assert property (wr_strobe |-> !write_protect_pin)
    else $error("write launched while protected");
  busy_len_a: assert property ($fell(write_busy) |-> s_q.busy_cnt == WR_TMR_W'(WR_CYCLES))
    else $error("write cycle length wrong");
endmodule

`default_nettype wire

// ==== verif/eeprom_link_test.sv ====
// Testbench joining master and slave ends with random and corner byte writes
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR time=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module eeprom_link_test;
  import eeprom_link_pkg::*;
  localparam int unsigned WR_N = 1000;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic req_valid = 1'h0;
  logic req_ready, done, nack, wr_strobe, write_busy;
  logic [1:0] nack_byte;
  logic [SA_SEL_W-1:0] req_sel = '0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [BYTE_W-1:0] req_data = '0;
  logic [ADDR_W-1:0] wr_addr, got_addr;
  logic [BYTE_W-1:0] wr_data, got_data;
  logic [2:0] pins = 3'h0;
  logic wp = 1'h0;
  logic wp_en = 1'h0;
  int n_fail = 0;
  int samples_checked = 0;
  int n_wr = 0;
  logic pend = 1'h0;  // A write was launched and not waited out
  int rnd;

  eeprom_link_if link();
  assign link.chip_select_pin_high = pins[2];
  assign link.chip_select_pin_mid = pins[1];
  assign link.chip_select_pin_low = pins[0];
  assign link.wp_drive = wp;
  assign link.wp_drive_en = wp_en;

  eeprom_master_end #(.QUARTER_CYCLES(8)) eeprom_master_end_i (.sys_clk(sys_clk), .rst(rst),
    .clk_en(1'h1), .link(link), .req_valid(req_valid), .req_ready(req_ready),
    .req_sel(req_sel), .req_addr(req_addr), .req_data(req_data), .done(done), .nack(nack),
    .nack_byte(nack_byte));
  eeprom_slave_end #(.WR_CYCLES(WR_N)) eeprom_slave_end_i (.sys_clk(sys_clk), .rst(rst),
    .clk_en(1'h1), .link(link), .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data),
    .write_busy(write_busy));
  eeprom_link_props #(.WR_CYCLES(WR_N)) eeprom_link_props_i (.sys_clk(sys_clk), .rst(rst),
    .scl(link.scl), .sda(link.sda), .host_sda_oe_n(link.host_sda_oe_n),
    .dev_sda_o(link.dev_sda_o), .dev_sda_oe_n(link.dev_sda_oe_n),
    .write_protect_pin(link.write_protect_pin), .wr_strobe(wr_strobe),
    .write_busy(write_busy));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, launched writes and watchdog
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  always @(negedge sys_clk) begin
    if (wr_strobe === 1'h1) begin
      n_wr++;
      got_addr = wr_addr;
      got_data = wr_data;
    end
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    n_fail++;
    end_sim;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Expected {refused, refused byte}: busy or select mismatch stop at byte 0
  function automatic logic [2:0] expect_resp(input logic [2:0] sel, input logic [2:0] p,
                                             input logic prot, input logic busy);
    if (busy || sel != p) begin
      return 3'h4;
    end
    return prot ? 3'h7 : 3'h0;
  endfunction

  // One byte write through the master, then checks of answer and launch
  task automatic xfer(input logic [2:0] sel, input logic [14:0] addr, input logic [7:0] data,
                      input logic wait_idle);
    logic [2:0] exp;
    logic busy0;
    int wr0;
    int k;
    busy0 = pend;
    exp = expect_resp(sel, pins, wp_en & wp, busy0);
    wr0 = n_wr;
    req_sel = sel;
    req_addr = addr;
    req_data = data;
    req_valid = 1'h1;
    @(negedge sys_clk);
    req_valid = 1'h0;
    `CHK(req_ready, 1'h0)
    k = 0;
    while (done !== 1'h1 && k < 5000) begin
      @(negedge sys_clk);
      k++;
    end
    `CHK(done, 1'h1)
    `CHK(req_ready, 1'h1)
    `CHK(nack, exp[2])
    if (exp[2]) `CHK(nack_byte, exp[1:0])
    repeat (8) @(negedge sys_clk);
    `CHK(n_wr == wr0 + 1, !exp[2])
    `CHK(write_busy, !exp[2] || busy0)
    if (!exp[2]) begin
      `CHK({got_addr, got_data}, {addr, data})
    end
    pend = (!exp[2] || busy0) && !wait_idle;
    k = 0;
    while (wait_idle && write_busy !== 1'h0 && k < 3000) begin
      @(negedge sys_clk);
      k++;
    end
  endtask

  task automatic end_sim;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rnd = $urandom(32'h7C4A7D1C);
    repeat (5) @(negedge sys_clk);
    rst = 1'h0;
    // Every strap setting: a matching write, then a mismatched select
    for (int i = 0; i < 8; i++) begin
      pins = 3'(i);
      wp = 1'($urandom);
      wp_en = 1'($urandom);
      xfer(3'(i), 15'($urandom), 8'($urandom), 1'h1);
      xfer(3'(i) ^ 3'(1 + $urandom % 7), 15'($urandom), 8'($urandom), 1'h1);
    end
    wp_en = 1'h0;
    xfer(pins, 15'h7FFF, 8'hA5, 1'h0);
    xfer(pins, 15'h0000, 8'h5A, 1'h1);
    wp_en = 1'h1;
    wp = 1'h1;
    xfer(pins, 15'h4321, 8'hC3, 1'h0);
    wp = 1'h0;
    xfer(pins, 15'h0000, 8'hFF, 1'h1);
    end_sim;
  end
endmodule

`undef CHK
`default_nettype wire
